// [src/cvrc_pkg.sv]
// cvrc_pkg: register map, field positions and reset values for the comparator/vref control bank
package cvrc_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          REG_W          = 16;
  localparam int          LVL_W          = 4;
  localparam int          TAP_W          = 6;
  // byte addresses of the two registers
  localparam logic [11:0] CMP_CTRL_ADDR  = 12'h000;
  localparam logic [11:0] VREF_CTRL_ADDR = 12'h004;
  // comparator_control fields
  localparam int          CMP1_POS_BIT   = 0;
  localparam int          CMP1_NEG_BIT   = 1;
  localparam int          CMP2_POS_BIT   = 2;
  localparam int          CMP2_NEG_BIT   = 3;
  localparam int          CMP1_INV_BIT   = 4;
  localparam int          CMP2_INV_BIT   = 5;
  localparam int          CMP1_RES_BIT   = 6;
  localparam int          CMP2_RES_BIT   = 7;
  localparam int          CMP1_DRV_BIT   = 8;
  localparam int          CMP2_DRV_BIT   = 9;
  localparam logic [5:0]  CMP_CFG_RST    = 6'h00;
  localparam logic [1:0]  CMP_DRV_RST    = 2'h0;
  // vref_control fields
  localparam int          LVL_LSB        = 0;
  localparam int          SRC_SEL_BIT    = 4;
  localparam int          RANGE_SEL_BIT  = 5;
  localparam int          VPIN_DRV_BIT   = 6;
  localparam int          VREF_EN_BIT    = 7;
  localparam logic [7:0]  VREF_CTRL_RST  = 8'h00;
  // ladder tap offsets: high range starts at 0, low range starts 8 of 32 taps up
  localparam logic [5:0]  TAP_OFS_LOW    = 6'h08;
  localparam logic [5:0]  TAP_OFS_HIGH   = 6'h00;
  localparam logic [5:0]  DIV_LOW        = 6'h20;
  localparam logic [5:0]  DIV_HIGH       = 6'h18;
  // input routing choices
  typedef enum logic [1:0] {CVRC_SRC_PIN_POS, CVRC_SRC_PIN_NEG, CVRC_SRC_LADDER} cvrc_src_t;
endpackage

// [src/cvrc_sync.sv]
// cvrc_sync: three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module cvrc_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r  <= 1'b0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q_r <= s3_r;
    end
  end

  assign q = q_r;
endmodule

// [src/cvrc_regs.sv]
// cvrc_regs: apb register bank steering two comparators and their voltage reference ladder
//
// Overview of operation
// - cmp2_invert set inverts comparator 2 result
// - cmp1_invert set inverts comparator 1 result
// - cmp2_neg_sel picks comparator 2 inverting input
// - cmp2_pos_sel picks pin or ladder, comparator 2
// - cmp1_neg_sel picks comparator 1 inverting input
// - cmp1_pos_sel picks pin or ladder, comparator 1
// - two ranges, sixteen levels, 4-bit code
// - bit 5 selects active reference range
// - range sets level step size
// - bit 4 selects supply or external source
`timescale 1ns/1ps
module cvrc_regs
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp1_raw,
  input  wire logic        cmp2_raw,
  output logic             cmp1_result,
  output logic             cmp2_result,
  output logic             cmp1_pin_drive,
  output logic             cmp2_pin_drive,
  output logic [1:0]       cmp1_pos_route,
  output logic [1:0]       cmp1_neg_route,
  output logic [1:0]       cmp2_pos_route,
  output logic [1:0]       cmp2_neg_route,
  output logic             vref_enable,
  output logic             vref_pin_drive,
  output logic             vref_range_sel,
  output logic             vref_source_sel,
  output logic [3:0]       vref_level_code,
  output logic [5:0]       ref_ladder_tap,
  output logic [5:0]       ref_ladder_div
);
  logic [5:0]  cmp_cfg_r;
  logic [1:0]  cmp_drv_r;
  logic [7:0]  vref_ctrl_r;
  logic [5:0]  cmp_cfg_nxt;
  logic [1:0]  cmp_drv_nxt;
  logic [7:0]  vref_ctrl_nxt;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        cmp1_res_r;
  logic        cmp2_res_r;
  logic [1:0]  c1p_r;
  logic [1:0]  c1n_r;
  logic [1:0]  c2p_r;
  logic [1:0]  c2n_r;
  logic [5:0]  tap_r;
  logic [5:0]  div_r;
  logic        cmp1_sync;
  logic        cmp2_sync;

  // routing of one selector bit to a source code
  function automatic cvrc_pkg::cvrc_src_t pos_route(input logic sel);
    pos_route = sel ? cvrc_pkg::CVRC_SRC_PIN_POS : cvrc_pkg::CVRC_SRC_LADDER;
  endfunction

  function automatic cvrc_pkg::cvrc_src_t neg_route(input logic sel);
    neg_route = sel ? cvrc_pkg::CVRC_SRC_PIN_POS : cvrc_pkg::CVRC_SRC_PIN_NEG;
  endfunction

  // comparator results arrive from the analog side, asynchronous to pclk
  cvrc_sync u_sync1
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (cmp1_raw),
    .q       (cmp1_sync)
  );

  cvrc_sync u_sync2
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (cmp2_raw),
    .q       (cmp2_sync)
  );

  // bus decode; zero wait states so access phase always completes
  wire         acc       = psel & penable;
  wire         hit_cmp   = (paddr == cvrc_pkg::CMP_CTRL_ADDR);
  wire         hit_vref  = (paddr == cvrc_pkg::VREF_CTRL_ADDR);
  wire         unmapped  = ~(hit_cmp | hit_vref);
  wire         wr_cmp0   = acc & pwrite & hit_cmp & pstrb[0];
  wire         wr_cmp1   = acc & pwrite & hit_cmp & pstrb[1];
  wire         wr_vref0  = acc & pwrite & hit_vref & pstrb[0];
  wire         setup_rd  = psel & ~penable & ~pwrite;

  assign cmp_cfg_nxt   = wr_cmp0 ? pwdata[cvrc_pkg::CMP2_INV_BIT:cvrc_pkg::CMP1_POS_BIT] : cmp_cfg_r;
  assign cmp_drv_nxt   = wr_cmp1 ? pwdata[cvrc_pkg::CMP2_DRV_BIT:cvrc_pkg::CMP1_DRV_BIT] : cmp_drv_r;
  assign vref_ctrl_nxt = wr_vref0 ? pwdata[cvrc_pkg::VREF_EN_BIT:cvrc_pkg::LVL_LSB] : vref_ctrl_r;

  // result bits are read-only: writes to bits 7:6 are dropped
  wire [31:0]  rd_cmp    = {16'h0000, 6'h00, cmp_drv_r, cmp2_res_r, cmp1_res_r, cmp_cfg_r};
  wire [31:0]  rd_vref   = {24'h000000, vref_ctrl_r};
  wire [31:0]  rd_mux    = hit_cmp ? rd_cmp : (hit_vref ? rd_vref : 32'h00000000);

  // inversion applied after synchronising so both paths see the same latency
  wire         res1_nxt  = cmp1_sync ^ cmp_cfg_r[cvrc_pkg::CMP1_INV_BIT];
  wire         res2_nxt  = cmp2_sync ^ cmp_cfg_r[cvrc_pkg::CMP2_INV_BIT];

  wire         rng       = vref_ctrl_r[cvrc_pkg::RANGE_SEL_BIT];
  wire [5:0]   lvl6      = {2'h0, vref_ctrl_r[cvrc_pkg::LVL_LSB +: cvrc_pkg::LVL_W]};
  // high range: code/24 of span; low range: (8+code)/32 of span
  wire [5:0]   tap_nxt   = lvl6 + (rng ? cvrc_pkg::TAP_OFS_HIGH : cvrc_pkg::TAP_OFS_LOW);
  wire [5:0]   div_nxt   = rng ? cvrc_pkg::DIV_HIGH : cvrc_pkg::DIV_LOW;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_cfg_r   <= cvrc_pkg::CMP_CFG_RST;
      cmp_drv_r   <= cvrc_pkg::CMP_DRV_RST;
      vref_ctrl_r <= cvrc_pkg::VREF_CTRL_RST;
    end
    else
    begin
      cmp_cfg_r   <= cmp_cfg_nxt;
      cmp_drv_r   <= cmp_drv_nxt;
      vref_ctrl_r <= vref_ctrl_nxt;
    end
  end

  // read data captured in the setup cycle, valid through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= setup_rd ? rd_mux : 32'h00000000;
      pslverr_r <= psel & ~penable & unmapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp1_res_r <= 1'b0;
      cmp2_res_r <= 1'b0;
      c1p_r      <= cvrc_pkg::CVRC_SRC_LADDER;
      c1n_r      <= cvrc_pkg::CVRC_SRC_PIN_NEG;
      c2p_r      <= cvrc_pkg::CVRC_SRC_LADDER;
      c2n_r      <= cvrc_pkg::CVRC_SRC_PIN_NEG;
      tap_r      <= cvrc_pkg::TAP_OFS_LOW;
      div_r      <= cvrc_pkg::DIV_LOW;
    end
    else
    begin
      cmp1_res_r <= res1_nxt;
      cmp2_res_r <= res2_nxt;
      c1p_r      <= pos_route(cmp_cfg_nxt[cvrc_pkg::CMP1_POS_BIT]);
      c1n_r      <= neg_route(cmp_cfg_nxt[cvrc_pkg::CMP1_NEG_BIT]);
      c2p_r      <= pos_route(cmp_cfg_nxt[cvrc_pkg::CMP2_POS_BIT]);
      c2n_r      <= neg_route(cmp_cfg_nxt[cvrc_pkg::CMP2_NEG_BIT]);
      tap_r      <= tap_nxt;
      div_r      <= div_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = 1'b1;
  assign pslverr         = pslverr_r;
  assign cmp1_result     = cmp1_res_r;
  assign cmp2_result     = cmp2_res_r;
  // no pin is driven here: the remap fabric outside must route these
  assign cmp1_pin_drive  = cmp_drv_r[0];
  assign cmp2_pin_drive  = cmp_drv_r[1];
  assign cmp1_pos_route  = c1p_r;
  assign cmp1_neg_route  = c1n_r;
  assign cmp2_pos_route  = c2p_r;
  assign cmp2_neg_route  = c2n_r;
  assign vref_enable     = vref_ctrl_r[cvrc_pkg::VREF_EN_BIT];
  assign vref_pin_drive  = vref_ctrl_r[cvrc_pkg::VPIN_DRV_BIT];
  assign vref_range_sel  = vref_ctrl_r[cvrc_pkg::RANGE_SEL_BIT];
  assign vref_source_sel = vref_ctrl_r[cvrc_pkg::SRC_SEL_BIT];
  // settling is left to software; no busy flag is kept
  assign vref_level_code = vref_ctrl_r[cvrc_pkg::LVL_LSB +: cvrc_pkg::LVL_W];
  assign ref_ladder_tap  = tap_r;
  assign ref_ladder_div  = div_r;

  a_inv_cmp1: assert property (@(posedge pclk) disable iff (!presetn)
    cmp1_result == ($past(cmp1_sync) ^ $past(cmp_cfg_r[cvrc_pkg::CMP1_INV_BIT])))
    else $error("cmp1 result polarity wrong");
  a_inv_cmp2: assert property (@(posedge pclk) disable iff (!presetn)
    cmp2_result == ($past(cmp2_sync) ^ $past(cmp_cfg_r[cvrc_pkg::CMP2_INV_BIT])))
    else $error("cmp2 result polarity wrong");
  a_route_cmp2_neg_sel: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp0 |=> cmp2_neg_route == ($past(pwdata[cvrc_pkg::CMP2_NEG_BIT]) ? 2'd0 : 2'd1)
    && cmp_cfg_r == $past(pwdata[cvrc_pkg::CMP2_INV_BIT:cvrc_pkg::CMP1_POS_BIT]))
    else $error("cmp2 negative route wrong");
  a_route_cmp2_pos_sel: assert property (@(posedge pclk) disable iff (!presetn)
    cmp2_pos_route == (cmp_cfg_r[cvrc_pkg::CMP2_POS_BIT] ? 2'd0 : 2'd2))
    else $error("cmp2 positive route wrong");
  a_route_cmp1_neg_sel: assert property (@(posedge pclk) disable iff (!presetn)
    cmp1_neg_route == (cmp_cfg_r[cvrc_pkg::CMP1_NEG_BIT] ? 2'd0 : 2'd1))
    else $error("cmp1 negative route wrong");
  a_route_cmp1_pos_sel: assert property (@(posedge pclk) disable iff (!presetn)
    cmp1_pos_route == (cmp_cfg_r[cvrc_pkg::CMP1_POS_BIT] ? 2'd0 : 2'd2))
    else $error("cmp1 positive route wrong");
  // tap and divider are registered from the current field value, so they trail it by one edge
  a_ladder_range: assert property (@(posedge pclk) disable iff (!presetn)
    ref_ladder_div == ($past(vref_range_sel) ? 6'd24 : 6'd32)
    && ref_ladder_tap == {2'h0, $past(vref_level_code)} + ($past(vref_range_sel) ? 6'd0 : 6'd8))
    else $error("ladder tap or step wrong");
  a_vref_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vref0 |=> vref_enable == $past(pwdata[7]) && vref_pin_drive == $past(pwdata[6])
    && vref_range_sel == $past(pwdata[5]) && vref_source_sel == $past(pwdata[4]))
    else $error("vref control write lost");
  a_vref_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_vref0 |=> $stable(vref_ctrl_r))
    else $error("vref control changed without write");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && unmapped) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");

  // register storage and hold
  a_drv_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp1
    |=> cmp_drv_r == $past(pwdata[cvrc_pkg::CMP2_DRV_BIT:cvrc_pkg::CMP1_DRV_BIT]))
    else $error("pin drive write lost");
  a_drv_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cmp1
    |=> $stable(cmp_drv_r))
    else $error("pin drive changed without write");
  a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_cmp0
    |=> $stable(cmp_cfg_r))
    else $error("comparator config changed without write");
  a_inv1_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp0
    |=> cmp_cfg_r[cvrc_pkg::CMP1_INV_BIT] == $past(pwdata[cvrc_pkg::CMP1_INV_BIT]))
    else $error("cmp1 invert write lost");
  a_inv2_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cmp0
    |=> cmp_cfg_r[cvrc_pkg::CMP2_INV_BIT] == $past(pwdata[cvrc_pkg::CMP2_INV_BIT]))
    else $error("cmp2 invert write lost");
  a_level_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vref0
    |=> vref_level_code == $past(pwdata[cvrc_pkg::LVL_LSB +: cvrc_pkg::LVL_W]))
    else $error("level code write lost");
  a_src_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vref0
    |=> vref_source_sel == $past(pwdata[cvrc_pkg::SRC_SEL_BIT]))
    else $error("source select write lost");
  a_range_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vref0
    |=> vref_range_sel == $past(pwdata[cvrc_pkg::RANGE_SEL_BIT]))
    else $error("range select write lost");
  a_pin_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vref0
    |=> vref_pin_drive == $past(pwdata[cvrc_pkg::VPIN_DRV_BIT]))
    else $error("reference pin drive write lost");
  a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_vref0
    |=> vref_enable == $past(pwdata[cvrc_pkg::VREF_EN_BIT]))
    else $error("reference enable write lost");

  // ladder and routing legality
  a_ladder_bounds: assert property (@(posedge pclk) disable iff (!presetn)
    ref_ladder_tap < ref_ladder_div
    && ref_ladder_tap >= cvrc_pkg::TAP_OFS_HIGH)
    else $error("ladder tap beyond divider");
  a_div_choice: assert property (@(posedge pclk) disable iff (!presetn)
    ref_ladder_div == cvrc_pkg::DIV_HIGH
    || ref_ladder_div == cvrc_pkg::DIV_LOW)
    else $error("ladder divider illegal");
  a_low_floor: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(vref_range_sel)
    |-> ref_ladder_tap >= cvrc_pkg::TAP_OFS_LOW)
    else $error("low range tap below floor");
  a_pos1_legal: assert property (@(posedge pclk) disable iff (!presetn)
    cmp1_pos_route == cvrc_pkg::CVRC_SRC_PIN_POS
    || cmp1_pos_route == cvrc_pkg::CVRC_SRC_LADDER)
    else $error("cmp1 positive route illegal");
  a_pos2_legal: assert property (@(posedge pclk) disable iff (!presetn)
    cmp2_pos_route == cvrc_pkg::CVRC_SRC_PIN_POS
    || cmp2_pos_route == cvrc_pkg::CVRC_SRC_LADDER)
    else $error("cmp2 positive route illegal");
  a_neg1_legal: assert property (@(posedge pclk) disable iff (!presetn)
    cmp1_neg_route == cvrc_pkg::CVRC_SRC_PIN_POS
    || cmp1_neg_route == cvrc_pkg::CVRC_SRC_PIN_NEG)
    else $error("cmp1 negative route illegal");
  a_neg2_legal: assert property (@(posedge pclk) disable iff (!presetn)
    cmp2_neg_route == cvrc_pkg::CVRC_SRC_PIN_POS
    || cmp2_neg_route == cvrc_pkg::CVRC_SRC_PIN_NEG)
    else $error("cmp2 negative route illegal");

  // read path, error response and result hold
  a_rd_vref: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && hit_vref)
    |=> prdata == {24'h000000, $past(vref_ctrl_r)})
    else $error("reference control read wrong");
  a_rd_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && hit_cmp)
    |=> prdata[cvrc_pkg::CMP2_INV_BIT:cvrc_pkg::CMP1_POS_BIT] == $past(cmp_cfg_r)
    && prdata[cvrc_pkg::CMP2_DRV_BIT:cvrc_pkg::CMP1_DRV_BIT] == $past(cmp_drv_r))
    else $error("comparator control read wrong");
  a_rd_results: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && hit_cmp)
    |=> prdata[cvrc_pkg::CMP1_RES_BIT] == $past(cmp1_result)
    && prdata[cvrc_pkg::CMP2_RES_BIT] == $past(cmp2_result))
    else $error("result bits read wrong");
  a_rd_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_rd
    |=> prdata == 32'h00000000)
    else $error("read data outside access phase");
  a_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && unmapped)
    |=> !pslverr)
    else $error("error flagged without unmapped access");
  a_unmapped_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && unmapped)
    |=> $stable(cmp_cfg_r) && $stable(cmp_drv_r) && $stable(vref_ctrl_r))
    else $error("unmapped write changed a register");
  a_res1_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(cmp1_sync) && $stable(cmp_cfg_r[cvrc_pkg::CMP1_INV_BIT])
    |=> $stable(cmp1_result))
    else $error("cmp1 result moved without cause");
  a_res2_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(cmp2_sync) && $stable(cmp_cfg_r[cvrc_pkg::CMP2_INV_BIT])
    |=> $stable(cmp2_result))
    else $error("cmp2 result moved without cause");

  c_vref_on: cover property (@(posedge pclk) disable iff (!presetn) wr_vref0 ##1 vref_enable);
  c_inverted: cover property (@(posedge pclk) disable iff (!presetn) cmp_cfg_r[cvrc_pkg::CMP1_INV_BIT] && cmp1_result);
  c_high_range: cover property (@(posedge pclk) disable iff (!presetn) vref_range_sel && vref_level_code == 4'hf);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_low_range: cover property (@(posedge pclk) disable iff (!presetn) !vref_range_sel && vref_level_code == 4'hf);
endmodule

// [tb/testbench.sv]
// testbench: random and corner-case register traffic for the comparator and reference control bank
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp1_raw;
  logic        cmp2_raw;
  logic        cmp1_result;
  logic        cmp2_result;
  logic        cmp1_pin_drive;
  logic        cmp2_pin_drive;
  logic [1:0]  cmp1_pos_route;
  logic [1:0]  cmp1_neg_route;
  logic [1:0]  cmp2_pos_route;
  logic [1:0]  cmp2_neg_route;
  logic        vref_enable;
  logic        vref_pin_drive;
  logic        vref_range_sel;
  logic        vref_source_sel;
  logic [3:0]  vref_level_code;
  logic [5:0]  ref_ladder_tap;
  logic [5:0]  ref_ladder_div;
  logic [9:0]  cc;
  logic [7:0]  vc;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;

  cvrc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .cmp1_result(cmp1_result), .cmp2_result(cmp2_result),
    .cmp1_pin_drive(cmp1_pin_drive), .cmp2_pin_drive(cmp2_pin_drive), .cmp1_pos_route(cmp1_pos_route),
    .cmp1_neg_route(cmp1_neg_route), .cmp2_pos_route(cmp2_pos_route), .cmp2_neg_route(cmp2_neg_route),
    .vref_enable(vref_enable), .vref_pin_drive(vref_pin_drive), .vref_range_sel(vref_range_sel),
    .vref_source_sel(vref_source_sel), .vref_level_code(vref_level_code),
    .ref_ladder_tap(ref_ladder_tap), .ref_ladder_div(ref_ladder_div));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // route codes: 0 positive pin, 1 negative pin, 2 ladder
  function automatic logic [1:0] pr(input logic s);
    return s ? 2'h0 : 2'h2;
  endfunction
  function automatic logic [1:0] nr(input logic s);
    return s ? 2'h0 : 2'h1;
  endfunction
  // coarse range steps by 1/24 from 0, fine by 1/32 from 8/32 up
  function automatic logic [11:0] ladder(input logic [7:0] v);
    return v[5] ? {{2'h0, v[3:0]}, 6'h18} : {{2'h0, v[3:0]} + 6'h08, 6'h20};
  endfunction

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // request held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // config outputs change with the register; ladder trails by one edge, results by the sync chain
  task automatic check_all;
    logic [31:0] rd;
    logic        err;
    chk({cmp2_pin_drive, cmp1_pin_drive}, cc[9:8]);
    chk({cmp2_neg_route, cmp2_pos_route, cmp1_neg_route, cmp1_pos_route},
        {nr(cc[3]), pr(cc[2]), nr(cc[1]), pr(cc[0])});
    chk({vref_enable, vref_pin_drive, vref_range_sel, vref_source_sel, vref_level_code}, vc);
    repeat (8) @(posedge pclk);
    #1;
    chk({ref_ladder_tap, ref_ladder_div}, ladder(vc));
    chk({cmp2_result, cmp1_result}, {cmp2_raw ^ cc[5], cmp1_raw ^ cc[4]});
    apb(1'b0, cvrc_pkg::CMP_CTRL_ADDR, 32'h0, 4'h0, rd, err);
    chk({err, rd}, {23'h0, cc[9:8], cmp2_raw ^ cc[5], cmp1_raw ^ cc[4], cc[5:0]});
    apb(1'b0, cvrc_pkg::VREF_CTRL_ADDR, 32'h0, 4'h0, rd, err);
    chk({err, rd}, {25'h0, vc});
  endtask

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [31:0] rnd;
    logic [31:0] rd;
    logic        err;
    logic [11:0] a;
    logic [3:0]  s;
    logic [1:0]  kind;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    cmp1_raw = 1'b0;
    cmp2_raw = 1'b0;
    cc = 10'h000;
    vc = 8'h00;
    rnd = $urandom(32'h88b2bb6a);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    for (int i = 0; i < 60; i++)
    begin
      rnd = $urandom;
      d = (i < 2) ? 32'hffffffff : (i < 4) ? 32'h0 : $urandom;
      s = (i < 4) ? 4'hf : rnd[3:0];
      kind = (i < 4) ? {i[0], 1'b0} : rnd[5:4];
      a = (kind == 2'h3) ? 12'h008 + {1'b0, rnd[14:6], 2'b00} :
          (kind == 2'h2) ? cvrc_pkg::VREF_CTRL_ADDR : cvrc_pkg::CMP_CTRL_ADDR;
      @(posedge pclk);
      cmp1_raw <= rnd[16];
      cmp2_raw <= rnd[17];
      apb(1'b1, a, d, s, rd, err);
      chk({39'h0, err}, {39'h0, kind == 2'h3});
      if (kind == 2'h3)
      begin
        apb(1'b0, a, 32'h0, 4'h0, rd, err);
        chk({err, rd}, {1'b1, 32'h0});
      end
      else if (kind == 2'h2)
      begin
        if (s[0])
          vc = d[7:0];
      end
      else
      begin
        if (s[0])
          cc[5:0] = d[5:0];
        if (s[1])
          cc[9:8] = d[9:8];
      end
      check_all();
    end
    // asynchronous reset in mid-run must bring every field back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cc = 10'h000;
    vc = 8'h00;
    check_all();
    final_report();
  end
endmodule
